// >>> hw/cssu_clock_ctrl.v
// Clock source switch controller with abort, sleep abort and two-speed start-up
// Summary of operation
// - Clearing the switch request while pending resets and aborts the switch logic.
// - Abort stops and resets the crystal timer and stops the loop unless the running source uses it.
// - Abort is accepted in every waiting stage of the switch.
// - A new switch request abandons the current one and starts afresh.
// - Low-byte write needs 0x46 then 0x57 unlock codes first.
// - Sleep during a switch aborts it, keeps old source, clears request.
// - Two-speed fuse set: power up on the fast RC source always.
// - Stay on fast RC until configured source is stable, then switch.
// - Turn fast RC off after two-speed switch unless monitor enabled.
// - Two-speed start-up runs even with clock switching disabled.
// - On completion current source field equals next source field.
// - Two-speed start-up to the RC source itself changes nothing.
// - Control register field layout as listed.
// - Divider, feedback and trim register field layout as listed.
// - Divider, feedback and trim registers take their documented reset values.
// - Control register reset value follows fuses; reset type has no effect.
// - Unimplemented bits read as zero.
// - Fuse register field layout as listed.
// - Trim codes raise RC frequency; code drives the RC trim output.
// - Unlocked byte is writable only in the next cycle.
// - Switch to the already running source is redundant and self-clears.
// - Switch config bits enable switching and monitor as decoded.
`timescale 1ns/100ps
`default_nettype none
`include "cssu_defines.vh"
module cssu_clock_ctrl #(
  parameter XTAL_WAIT = `CSSU_XTAL_WAIT
) (
  input wire clk, // System clock, 50 MHz
  input wire reset, // Synchronous reset, active high
  input wire por, // High with reset when the reset is a power-on one
  input wire [2:0] reg_addr, // Register word index
  input wire [15:0] reg_wdata, // Write data
  input wire [1:0] reg_lanes, // Byte lanes written: bit0 low, bit1 high
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [15:0] reg_rdata_ff, // Read data, cycle after the read strobe
  input wire [15:0] sel_fuse, // Start-up source fuses
  input wire [15:0] cfg_fuse, // Oscillator configuration fuses
  input wire sleep_req, // Power-save instruction executing
  input wire src_ready_pin, // New oscillator running, asynchronous
  input wire pll_lock_pin, // Loop locked, asynchronous
  input wire clk_fail, // Monitor detected clock failure, one pulse
  output reg [2:0] sys_src_ff, // Source driving the system clock
  output reg [2:0] osc_on_src_ff, // Source being started for a switch
  output reg osc_start_ff, // Start the new oscillator
  output reg pll_run_ff, // Run the loop
  output reg frc_on_ff, // Fast RC oscillator enabled
  output reg [5:0] rc_trim_ff, // RC trim code to the oscillator
  output reg sleep_ack_ff // Sleep may proceed
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_XTAL = 4'b0010;
  localparam ST_LOCK = 4'b0100;
  localparam ST_DONE = 4'b1000;

  // Sequencer stages, one-hot
  // Idle: no switch under way, the running source is current_source_sel, but fast RC after a reset with two-speed fuse clear
  // Xtal: new source enabled, start-up timer and ready pin awaited
  // Lock: new source runs, loop lock awaited before the hand-over
  // Done: one cycle in which the system clock moves to the new source
  // Only Xtal and Lock can be aborted; Done is a single committed step,
  // so an abort there would race the hand-over and is not offered
  // Register file: control, divider, loop feedback
  reg [15:0] ctrl_ff;
  reg [15:0] div_ff;
  reg [15:0] fbd_ff;
  // Sequencer state and its next value
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  // Crystal start-up countdown; zero for sources that need no wait
  reg [15:0] xtal_cnt_ff;
  reg [1:0] lo_key_ff; // Low unlock progress: 1 first key seen, 2 unlocked
  reg [1:0] hi_key_ff; // High unlock progress, same coding
  // Set once the fuse load after reset has been taken
  reg two_speed_ff;
  // Synchroniser flops; only the second stage is read by logic
  reg rdy_s1_ff;
  reg rdy_s2_ff;
  reg lock_s1_ff;
  reg lock_s2_ff;

  // Decoder for sources needing the loop
  function uses_pll;
    input [2:0] src;
    begin
      uses_pll = (src == `CSSU_SRC_FRCPLL) || (src == `CSSU_SRC_PRIPLL);
    end
  endfunction

  // Crystal sources need the start-up timer
  function is_xtal;
    input [2:0] src;
    begin
      is_xtal = (src == 3'h2) || (src == 3'h3) || (src == 3'h4);
    end
  endfunction

  wire sw_disabled = cfg_fuse[`CSSU_SWDIS_BIT];
  wire mon_enabled = !cfg_fuse[`CSSU_SWDIS_BIT] && !cfg_fuse[`CSSU_MONDIS_BIT];
  wire [2:0] init_src = sel_fuse[`CSSU_INIT_HI:`CSSU_INIT_LO];
  wire [2:0] cur_src = ctrl_ff[`CSSU_CUR_HI:`CSSU_CUR_LO];
  wire [2:0] nxt_src = ctrl_ff[`CSSU_NXT_HI:`CSSU_NXT_LO];
  wire wr_ctrl = reg_wr && (reg_addr == `CSSU_OFS_CTRL);
  wire lo_open = lo_key_ff == 2'h2;
  wire hi_open = hi_key_ff == 2'h2;
  wire wr_lo = wr_ctrl && reg_lanes[0] && lo_open;
  wire wr_hi = wr_ctrl && reg_lanes[1] && hi_open;
  wire req_set = wr_lo && reg_wdata[`CSSU_SWREQ_BIT] && !sw_disabled;
  wire req_clr = wr_lo && !reg_wdata[`CSSU_SWREQ_BIT];
  wire ready_ok = rdy_s2_ff;
  wire lock_ok = lock_s2_ff;

  // Two-flop synchronisers for the oscillator status pins
  // The status pins come from free-running analogue blocks, so a
  // single flop could go metastable; two cycles of latency are cheap
  // against the start-up times involved
  always @(posedge clk) begin
    if (reset) begin
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
    end else begin
      rdy_s1_ff <= src_ready_pin;
      rdy_s2_ff <= rdy_s1_ff;
      lock_s1_ff <= pll_lock_pin;
      lock_s2_ff <= lock_s1_ff;
    end
  end

  // Unlock sequence trackers; a key must follow the other directly
  // Any other cycle, idle ones included, drops the tracker back to
  // locked, so the byte is open for exactly one cycle after key two
  always @(posedge clk) begin
    if (reset) begin
      lo_key_ff <= 2'h0;
      hi_key_ff <= 2'h0;
    end else begin
      if (wr_ctrl && reg_lanes == `CSSU_LANE_LO && lo_key_ff != 2'h2 &&
          reg_wdata[7:0] == `CSSU_LO_KEY1)
        lo_key_ff <= 2'h1;
      else if (wr_ctrl && reg_lanes == `CSSU_LANE_LO && lo_key_ff == 2'h1 &&
               reg_wdata[7:0] == `CSSU_LO_KEY2)
        lo_key_ff <= 2'h2;
      else
        lo_key_ff <= 2'h0;
      if (wr_ctrl && reg_lanes == `CSSU_LANE_HI && hi_key_ff != 2'h2 &&
          reg_wdata[15:8] == `CSSU_HI_KEY1)
        hi_key_ff <= 2'h1;
      else if (wr_ctrl && reg_lanes == `CSSU_LANE_HI && hi_key_ff == 2'h1 &&
               reg_wdata[15:8] == `CSSU_HI_KEY2)
        hi_key_ff <= 2'h2;
      else
        hi_key_ff <= 2'h0;
    end
  end

  // Switch sequencer: each waiting stage falls back to idle on abort
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (ctrl_ff[`CSSU_SWREQ_BIT] && nxt_src != cur_src)
          nxt_state = ST_XTAL;
      end
      ST_XTAL: begin
        if (xtal_cnt_ff == 16'h0_000 && ready_ok)
          nxt_state = uses_pll(osc_on_src_ff) ? ST_LOCK : ST_DONE;
      end
      ST_LOCK: begin
        if (lock_ok)
          nxt_state = ST_DONE;
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
    if (state_ff != ST_IDLE && state_ff != ST_DONE &&
        (req_clr || req_set || sleep_req))
      nxt_state = ST_IDLE;
  end

  // Sequencer state, crystal timer and oscillator enables
  always @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      xtal_cnt_ff <= 16'h0_000;
      osc_on_src_ff <= `CSSU_SRC_FRC;
      osc_start_ff <= 1'b0;
      pll_run_ff <= 1'b0;
      sleep_ack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sleep_ack_ff <= sleep_req;
      if (nxt_state == ST_XTAL && state_ff != ST_XTAL) begin
        osc_on_src_ff <= nxt_src;
        osc_start_ff <= 1'b1;
        pll_run_ff <= uses_pll(nxt_src);
        xtal_cnt_ff <= is_xtal(nxt_src) ? XTAL_WAIT[15:0] : 16'h0_000;
      end else if (nxt_state == ST_IDLE && state_ff != ST_DONE &&
                   state_ff != ST_IDLE) begin
        osc_start_ff <= 1'b0;
        pll_run_ff <= uses_pll(sys_src_ff);
        xtal_cnt_ff <= 16'h0_000;
      end else if (state_ff == ST_XTAL && xtal_cnt_ff != 16'h0_000) begin
        xtal_cnt_ff <= xtal_cnt_ff - 16'h0_001;
      end else if (state_ff == ST_DONE) begin
        osc_start_ff <= 1'b0;
      end
    end
  end

  // System clock selection and fast RC enable
  // The fast RC must be running again whenever it becomes the source;
  // otherwise a switch back to it would leave the system clock dead
  always @(posedge clk) begin
    if (reset) begin
      sys_src_ff <= `CSSU_SRC_FRC;
      frc_on_ff <= 1'b1;
    end else if (state_ff == ST_DONE) begin
      sys_src_ff <= osc_on_src_ff;
      if (osc_on_src_ff != `CSSU_SRC_FRC && osc_on_src_ff != `CSSU_SRC_FRCPLL)
        frc_on_ff <= mon_enabled;
      else
        frc_on_ff <= 1'b1;
    end else if (state_ff == ST_XTAL &&
                 (osc_on_src_ff == `CSSU_SRC_FRC || osc_on_src_ff == `CSSU_SRC_FRCPLL)) begin
      frc_on_ff <= 1'b1;
    end
  end

  // Control register; every reset, power-on or not, clears the sticky locks
  // Reset parks current_source_sel at 7 as a marker; the first cycle
  // after release replaces it from the fuses, which is why the first
  // software request must wait one cycle after reset
  always @(posedge clk) begin
    if (reset) begin
      two_speed_ff <= 1'b0;
      ctrl_ff <= `CSSU_CTRL_RST;
    end else if (state_ff == ST_IDLE && two_speed_ff == 1'b0 && ctrl_ff == 16'hF_FFF) begin
      ctrl_ff <= ctrl_ff;
    end else begin
      if (two_speed_ff == 1'b0 && ctrl_ff[15]) begin
        ctrl_ff[15] <= 1'b0;
      end
      if (wr_hi)
        ctrl_ff[`CSSU_NXT_HI:`CSSU_NXT_LO] <= reg_wdata[`CSSU_NXT_HI:`CSSU_NXT_LO];
      if (wr_lo) begin
        if (reg_wdata[`CSSU_SWLOCK_BIT])
          ctrl_ff[`CSSU_SWLOCK_BIT] <= 1'b1;
        if (reg_wdata[`CSSU_PINLOCK_BIT] || !cfg_fuse[5])
          ctrl_ff[`CSSU_PINLOCK_BIT] <= reg_wdata[`CSSU_PINLOCK_BIT];
        ctrl_ff[`CSSU_SECEN_BIT] <= reg_wdata[`CSSU_SECEN_BIT];
        if (req_clr)
          ctrl_ff[`CSSU_SWREQ_BIT] <= 1'b0;
        if (req_set && !ctrl_ff[`CSSU_SWLOCK_BIT])
          ctrl_ff[`CSSU_SWREQ_BIT] <= 1'b1;
        if (req_set)
          ctrl_ff[`CSSU_PLLLOCK_BIT] <= 1'b0;
      end
      if (clk_fail)
        ctrl_ff[`CSSU_CFAIL_BIT] <= 1'b1; // Set wins over clear
      else if (wr_lo && !reg_wdata[`CSSU_CFAIL_BIT])
        ctrl_ff[`CSSU_CFAIL_BIT] <= 1'b0;
      if (lock_ok && pll_run_ff)
        ctrl_ff[`CSSU_PLLLOCK_BIT] <= 1'b1;
      if (state_ff == ST_IDLE && ctrl_ff[`CSSU_SWREQ_BIT] && nxt_src == cur_src && !req_set)
        ctrl_ff[`CSSU_SWREQ_BIT] <= 1'b0;
      if (sleep_req && state_ff != ST_IDLE && !req_set)
        ctrl_ff[`CSSU_SWREQ_BIT] <= 1'b0;
      if (state_ff == ST_DONE) begin
        ctrl_ff[`CSSU_CUR_HI:`CSSU_CUR_LO] <= osc_on_src_ff;
        ctrl_ff[`CSSU_NXT_HI:`CSSU_NXT_LO] <= osc_on_src_ff;
        if (!req_set)
          ctrl_ff[`CSSU_SWREQ_BIT] <= 1'b0;
        two_speed_ff <= 1'b1;
      end
      // Reset load of source fields taken one cycle after release
      if (!two_speed_ff && state_ff == ST_IDLE && !ctrl_ff[`CSSU_SWREQ_BIT] &&
          ctrl_ff[`CSSU_CUR_HI:`CSSU_CUR_LO] == 3'h7) begin
        two_speed_ff <= 1'b1;
        if (!por)
          ctrl_ff[`CSSU_SWLOCK_BIT] <= ctrl_ff[`CSSU_SWLOCK_BIT];
        if (sel_fuse[`CSSU_TWO_SPEED_BIT] && init_src != `CSSU_SRC_FRC) begin
          ctrl_ff[`CSSU_CUR_HI:`CSSU_CUR_LO] <= `CSSU_SRC_FRC;
          ctrl_ff[`CSSU_NXT_HI:`CSSU_NXT_LO] <= init_src;
          ctrl_ff[`CSSU_SWREQ_BIT] <= 1'b1;
        end else begin
          ctrl_ff[`CSSU_CUR_HI:`CSSU_CUR_LO] <= init_src;
          ctrl_ff[`CSSU_NXT_HI:`CSSU_NXT_LO] <= init_src;
        end
      end
    end
  end

  // Divider, feedback and trim registers; plain writes with lane enables
  always @(posedge clk) begin
    if (reset) begin
      div_ff <= `CSSU_DIV_RST;
      fbd_ff <= `CSSU_FBD_RST;
      rc_trim_ff <= 6'h00;
    end else if (reg_wr) begin
      if (reg_addr == `CSSU_OFS_DIV) begin
        if (reg_lanes[0])
          div_ff[7:0] <= reg_wdata[7:0];
        if (reg_lanes[1])
          div_ff[15:8] <= reg_wdata[15:8];
      end
      if (reg_addr == `CSSU_OFS_FBD) begin
        if (reg_lanes[0])
          fbd_ff[7:0] <= reg_wdata[7:0];
        if (reg_lanes[1])
          fbd_ff[8] <= reg_wdata[8];
      end
      if (reg_addr == `CSSU_OFS_TRIM && reg_lanes[0])
        rc_trim_ff <= reg_wdata[5:0];
    end
  end

  // Read mux; unmapped offsets and unimplemented bits return zero
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata_ff <= 16'h0_000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CSSU_OFS_CTRL: reg_rdata_ff <= ctrl_ff & `CSSU_CTRL_MASK;
        `CSSU_OFS_DIV: reg_rdata_ff <= div_ff & `CSSU_DIV_MASK;
        `CSSU_OFS_FBD: reg_rdata_ff <= fbd_ff & `CSSU_FBD_MASK;
        `CSSU_OFS_TRIM: reg_rdata_ff <= {10'h000, rc_trim_ff};
        `CSSU_OFS_SEL_FUSE: reg_rdata_ff <= sel_fuse & 16'h0_0A7;
        `CSSU_OFS_CFG_FUSE: reg_rdata_ff <= cfg_fuse & 16'h0_0E7;
        default: reg_rdata_ff <= 16'h0_000;
      endcase
    end else begin
      reg_rdata_ff <= 16'h0_000;
    end
  end
endmodule
`default_nettype wire

// >>> pkg/cssu_defines.vh
// Register offsets, field positions, reset values and timing counts of the clock controller
`ifndef CSSU_DEFINES_VH
`define CSSU_DEFINES_VH
// Register offsets (word index on the plain register port)
`define CSSU_OFS_CTRL 3'h0
`define CSSU_OFS_DIV 3'h1
`define CSSU_OFS_FBD 3'h2
`define CSSU_OFS_TRIM 3'h3
`define CSSU_OFS_SEL_FUSE 3'h4
`define CSSU_OFS_CFG_FUSE 3'h5
// Control register fields
`define CSSU_CUR_HI 14
`define CSSU_CUR_LO 12
`define CSSU_NXT_HI 10
`define CSSU_NXT_LO 8
`define CSSU_SWLOCK_BIT 7
`define CSSU_PINLOCK_BIT 6
`define CSSU_PLLLOCK_BIT 5
`define CSSU_CFAIL_BIT 3
`define CSSU_SECEN_BIT 1
`define CSSU_SWREQ_BIT 0
// Implemented bit masks
`define CSSU_CTRL_MASK 16'h7_7EB
`define CSSU_DIV_MASK 16'hF_FDF
`define CSSU_FBD_MASK 16'h0_1FF
`define CSSU_TRIM_MASK 16'h0_03F
// Reset values
`define CSSU_CTRL_RST 16'h7_700
`define CSSU_DIV_RST 16'h3_040
`define CSSU_FBD_RST 16'h0_030
`define CSSU_TRIM_RST 16'h0_000
// Fuse fields
`define CSSU_TWO_SPEED_BIT 7
`define CSSU_INIT_HI 2
`define CSSU_INIT_LO 0
`define CSSU_SWDIS_BIT 7
`define CSSU_MONDIS_BIT 6
// Unlock codes for the control register bytes
`define CSSU_LO_KEY1 8'h46
`define CSSU_LO_KEY2 8'h57
`define CSSU_HI_KEY1 8'h78
`define CSSU_HI_KEY2 8'h9A
// Source codes
`define CSSU_SRC_FRC 3'h0
`define CSSU_SRC_FRCPLL 3'h1
`define CSSU_SRC_PRIPLL 3'h3
// Crystal start-up wait, in system clock cycles
`define CSSU_XTAL_WAIT 1024
// Byte-lane codes
`define CSSU_LANE_LO 2'h1
`define CSSU_LANE_HI 2'h2
`endif

// >>> tb/cssu_ctrl_sva.sv
// Port assertions for the clock switch controller
`timescale 1ns/100ps
`default_nettype none
`include "cssu_defines.vh"
module cssu_ctrl_sva (
  input wire clk, // System clock
  input wire reset, // Sync reset
  input wire [2:0] reg_addr, // Register index
  input wire [15:0] reg_wdata, // Write data
  input wire [1:0] reg_lanes, // Byte lanes
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [15:0] reg_rdata_ff, // Read data
  input wire [15:0] sel_fuse, // Start-up fuses
  input wire [15:0] cfg_fuse, // Config fuses
  input wire sleep_req, // Power-save request
  input wire [2:0] sys_src_ff, // Running source
  input wire [2:0] osc_on_src_ff, // Target source
  input wire osc_start_ff, // Target starting
  input wire frc_on_ff, // Fast RC on
  input wire [5:0] rc_trim_ff, // Trim code
  input wire sleep_ack_ff // Sleep go-ahead
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Write strobes of interest and the two-speed fuse bit
  wire lo_wr = reg_wr && reg_addr == `CSSU_OFS_CTRL && reg_lanes[0];
  wire trim_wr = reg_wr && reg_addr == `CSSU_OFS_TRIM && reg_lanes[0];
  wire two_spd = sel_fuse[`CSSU_TWO_SPEED_BIT];
  // Unlock pair, then the request cleared in the very next cycle
  sequence s_key_lo;
    lo_wr && reg_wdata[7:0] == `CSSU_LO_KEY1 ##1 lo_wr && reg_wdata[7:0] == `CSSU_LO_KEY2;
  endsequence
  sequence s_abort;
    s_key_lo ##1 (lo_wr && !reg_wdata[`CSSU_SWREQ_BIT]);
  endsequence
  property p_abort_stop; s_abort |-> ##[1:2] !osc_start_ff; endproperty
  a_abort_stop: assert property (p_abort_stop) else $error("abort left start on");
  property p_abort_keep; s_abort |=> $stable(sys_src_ff) [*3]; endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort moved clock");
  property p_sleep_abort; $rose(sleep_req) && osc_start_ff |-> ##[1:2] !osc_start_ff; endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep kept switch");
  property p_sleep_ack; sleep_ack_ff == $past(sleep_req); endproperty
  a_sleep_ack: assert property (p_sleep_ack) else $error("sleep go-ahead late");
  // Start-up always lands on the fast RC first
  property p_two_frc; $fell(reset) && two_spd |-> sys_src_ff == `CSSU_SRC_FRC && frc_on_ff;
  endproperty
  a_two_frc: assert property (p_two_frc) else $error("start-up not on fast RC");
  property p_two_go;
    $fell(reset) && two_spd && sel_fuse[2:0] inside {3'h2, 3'h3, 3'h4} |-> ##[1:6] osc_start_ff;
  endproperty
  a_two_go: assert property (p_two_go) else $error("no automatic switch");
  property p_two_rc; $fell(reset) && two_spd && sel_fuse[2:0] == 3'h0 |-> !osc_start_ff [*8];
  endproperty
  a_two_rc: assert property (p_two_rc) else $error("needless start-up switch");
  // Guard against the reset load of sys_src_ff right after reset
  property p_target;
    $changed(sys_src_ff) && !$past(reset) && !$past(reset, 2) |-> sys_src_ff == $past(osc_on_src_ff);
  endproperty
  a_target: assert property (p_target) else $error("switched to wrong source");
  property p_frc_off;
    $changed(sys_src_ff) && $past(sys_src_ff) == 3'h0 && sys_src_ff inside {3'h2, 3'h3, 3'h4}
      |-> ##[0:2] (frc_on_ff == (cfg_fuse[7:6] == 2'h0));
  endproperty
  a_frc_off: assert property (p_frc_off) else $error("fast RC state wrong");
  property p_trim; trim_wr |=> rc_trim_ff == $past(reg_wdata[5:0]); endproperty
  a_trim: assert property (p_trim) else $error("trim code not applied");
  property p_zero;
    reg_rd && reg_addr == `CSSU_OFS_CTRL |=> (reg_rdata_ff & ~`CSSU_CTRL_MASK) == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("unused control bit set");
endmodule
bind cssu_clock_ctrl cssu_ctrl_sva chk_u (.clk, .reset, .reg_addr, .reg_wdata, .reg_lanes,
  .reg_wr, .reg_rd, .reg_rdata_ff, .sel_fuse, .cfg_fuse, .sleep_req, .sys_src_ff,
  .osc_on_src_ff, .osc_start_ff, .frc_on_ff, .rc_trim_ff, .sleep_ack_ff);
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the clock switch controller
`timescale 1ns/100ps
`default_nettype none
`include "cssu_defines.vh"
module tb;
  logic clk, reset, por, reg_wr, reg_rd, sleep_req, src_ready_pin, pll_lock_pin, clk_fail;
  logic [2:0] reg_addr;
  logic [1:0] reg_lanes;
  logic [15:0] reg_wdata, sel_fuse, cfg_fuse, v;
  wire [15:0] reg_rdata_ff;
  wire [2:0] sys_src_ff, osc_on_src_ff;
  wire [5:0] rc_trim_ff;
  wire osc_start_ff, pll_run_ff, frc_on_ff, sleep_ack_ff;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] cf [2] = '{16'h0080, 16'h0000};
  logic [15:0] rv [3] = '{16'h3040, 16'h0030, 16'h0000};
  logic [15:0] mk [3] = '{16'hFFDF, 16'h01FF, 16'h003F};
  // Short crystal wait keeps the run brief
  cssu_clock_ctrl #(.XTAL_WAIT(8)) dut_u (.clk, .reset, .por, .reg_addr, .reg_wdata,
    .reg_lanes, .reg_wr, .reg_rd, .reg_rdata_ff, .sel_fuse, .cfg_fuse, .sleep_req,
    .src_ready_pin, .pll_lock_pin, .clk_fail, .sys_src_ff, .osc_on_src_ff, .osc_start_ff,
    .pll_run_ff, .frc_on_ff, .rc_trim_ff, .sleep_ack_ff);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard, far above the sequence length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bus cycles; each drives at a rising edge, write strobe held until idle
  task automatic wr(input logic [2:0] a, input logic [1:0] l, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_lanes <= l;
    reg_wdata <= d;
    reg_wr <= 1'b1;
  endtask
  task automatic idle();
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata_ff;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Key pair then the byte itself, back to back
  task automatic ctl(input logic hi, input logic [7:0] d);
    logic [7:0] b;
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? (hi ? `CSSU_HI_KEY1 : `CSSU_LO_KEY1) : (i == 1) ? (hi ? `CSSU_HI_KEY2 :
        `CSSU_LO_KEY2) : d;
      wr(`CSSU_OFS_CTRL, hi ? `CSSU_LANE_HI : `CSSU_LANE_LO, hi ? {b, 8'h00} : {8'h00, b});
    end
    idle();
  endtask
  task automatic rst(input logic [15:0] c);
    @(posedge clk);
    cfg_fuse <= c;
    reset <= 1'b1;
    por <= 1'b1;
    src_ready_pin <= 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    cyc(2);
  endtask
  task automatic wait_src(input logic [2:0] s);
    int n;
    n = 0;
    while (sys_src_ff !== s && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(16'(sys_src_ff), 16'(s));
  endtask
  task automatic ready(input logic r);
    @(posedge clk);
    src_ready_pin <= r;
    pll_lock_pin <= 1'b1;
  endtask
  initial begin
    {reset, por, reg_wr, reg_rd, sleep_req, src_ready_pin, pll_lock_pin, clk_fail} = 8'hC2;
    reg_addr = 3'h0;
    reg_lanes = 2'h0;
    reg_wdata = 16'h0000;
    sel_fuse = 16'h00A3;
    cfg_fuse = 16'h0080;
    // Start-up with switching off, then with the monitor on
    foreach (cf[i]) begin
      rst(cf[i]);
      chk(16'(sys_src_ff), 16'h0000);
      rd(`CSSU_OFS_CTRL);
      chk(v & 16'h7701, 16'h0301);
      for (int a = 1; a < 4; a++) begin
        rd(3'(a));
        chk(v, rv[a-1]);
      end
      rd(`CSSU_OFS_SEL_FUSE);
      chk(v, sel_fuse);
      cyc(30);
      chk(16'(sys_src_ff), 16'h0000);
      ready(1'b1);
      wait_src(3'h3);
      cyc(3);
      chk(16'(frc_on_ff), 16'(cf[i][7:6] == 2'h0));
      rd(`CSSU_OFS_CTRL);
      chk(v & 16'h7701, 16'h3300);
      if (cf[i][7]) begin
        ctl(1'b1, 8'h00);
        ctl(1'b0, 8'h01);
        cyc(4);
        chk(16'(osc_start_ff), 16'h0000);
      end
    end
    ctl(1'b0, 8'h01);
    cyc(3);
    rd(`CSSU_OFS_CTRL);
    chk(v & 16'h0001, 16'h0000);
    // Abort with one timer cycle left and late while waiting for ready
    ready(1'b0);
    ctl(1'b1, 8'h02);
    for (int d = 6; d < 20; d += 8) begin
      ctl(1'b0, 8'h01);
      cyc(d);
      chk(16'(osc_start_ff), 16'h0001);
      ctl(1'b0, 8'h00);
      cyc(3);
      chk(16'(osc_start_ff), 16'h0000);
      rd(`CSSU_OFS_CTRL);
      chk(v & 16'h7701, 16'h3200);
    end
    ready(1'b1);
    ctl(1'b0, 8'h01);
    cyc(4);
    chk(16'(sys_src_ff), 16'h0003);
    wait_src(3'h2);
    // Second request replaces the pending one
    ready(1'b0);
    ctl(1'b1, 8'h03);
    ctl(1'b0, 8'h01);
    ctl(1'b1, 8'h00);
    ctl(1'b0, 8'h01);
    cyc(3);
    chk(16'(osc_on_src_ff), 16'h0000);
    ready(1'b1);
    wait_src(3'h0);
    // Clears without a fresh unlock are ignored, sleep aborts
    ready(1'b0);
    ctl(1'b1, 8'h03);
    ctl(1'b0, 8'h01);
    wr(`CSSU_OFS_CTRL, `CSSU_LANE_LO, 16'h0000);
    wr(`CSSU_OFS_CTRL, `CSSU_LANE_LO, 16'h0046);
    wr(`CSSU_OFS_CTRL, `CSSU_LANE_LO, 16'h0057);
    idle();
    wr(`CSSU_OFS_CTRL, `CSSU_LANE_LO, 16'h0000);
    idle();
    cyc(3);
    chk(16'(osc_start_ff), 16'h0001);
    @(posedge clk);
    sleep_req <= 1'b1;
    cyc(3);
    chk(16'(osc_start_ff), 16'h0000);
    chk(16'(sleep_ack_ff), 16'h0001);
    rd(`CSSU_OFS_CTRL);
    chk(v & 16'h7701, 16'h0300);
    @(posedge clk);
    sleep_req <= 1'b0;
    clk_fail <= 1'b1;
    @(posedge clk);
    clk_fail <= 1'b0;
    rd(`CSSU_OFS_CTRL);
    chk(v & 16'h0008, 16'h0008);
    // All-ones writes read back only implemented bits
    for (int a = 1; a < 4; a++) begin
      wr(3'(a), 2'h3, 16'hFFFF);
      idle();
      rd(3'(a));
      chk(v, mk[a-1]);
    end
    wr(`CSSU_OFS_TRIM, 2'h3, 16'h001E);
    idle();
    cyc(1);
    chk(16'(rc_trim_ff), 16'h001E);
    @(posedge clk);
    sel_fuse <= 16'h00A0;
    rst(16'h0000);
    cyc(10);
    chk(16'(osc_start_ff), 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
